// File: logic/rr_alu_pkg.sv
// constants, types and register map of the rotate-right / subtract-with-borrow alu
// assumes one pclk domain and an apb master that holds each request until pready
// Operation
// - rotate memory byte right in place, flags kept
// - rotate right into accumulator, memory and flags kept
// - nine-bit rotate through carry, in place
// - rotate through carry into accumulator, memory kept
// - accumulator minus memory minus inverted carry
// - carry set without borrow, cleared on borrow
// - subtract updates ov, z, ac, c, extended flags
package rr_alu_pkg;

    localparam int unsigned ADDR_W = 12;
    localparam int unsigned DATA_W = 8;

    // register byte addresses
    localparam logic [ADDR_W-1:0] ACC_OFFSET = 12'h000;
    localparam logic [ADDR_W-1:0] MEM_OFFSET = 12'h004;
    localparam logic [ADDR_W-1:0] STATUS_OFFSET = 12'h008;
    localparam logic [ADDR_W-1:0] CMD_OFFSET = 12'h00C;

    // status field positions
    localparam int unsigned C_POS = 0;
    localparam int unsigned AC_POS = 1;
    localparam int unsigned Z_POS = 2;
    localparam int unsigned OV_POS = 3;
    localparam int unsigned SIGNED_CMP_POS = 4;
    localparam int unsigned CHAINED_ZERO_POS = 5;
    localparam int unsigned FLAG_W = 6;

    // reset values
    localparam logic [DATA_W-1:0] ACC_RESET = 8'h00;
    localparam logic [DATA_W-1:0] MEM_RESET = 8'h00;
    localparam logic [FLAG_W-1:0] FLAGS_RESET = 6'h00;

    // command codes written to the command register, one-hot except OP_NONE, the reset value
    typedef enum logic [4:0] {
        OP_NONE = 5'h00,
        OP_ROTATE_MEM_RIGHT = 5'h01,
        OP_ROTATE_RIGHT_TO_ACC = 5'h02,
        OP_ROTATE_RIGHT_THRU_CARRY = 5'h04,
        OP_ROTATE_RIGHT_THRU_CARRY_TO_ACC = 5'h08,
        OP_SUBTRACT_WITH_BORROW_TO_ACC = 5'h10
    } op_t;

    // packed order matches the status field positions
    typedef struct packed {
        logic chained_zero_flag;
        logic signed_compare_flag;
        logic ov;
        logic z;
        logic ac;
        logic c;
    } flags_t;

    typedef struct packed {
        logic [DATA_W-1:0] acc;
        logic [DATA_W-1:0] mem;
        flags_t flags;
        op_t last_op;
    } alu_state_t;

    typedef struct packed {
        logic [DATA_W-1:0] diff;
        flags_t flags;
    } sub_result_t;

endpackage

// File: logic/sub_borrow_unit.sv
// eight-bit subtract with borrow and its status flags, purely combinational
// assumes the caller registers the result; carry in means no borrow pending
`timescale 1ns/1ps
`default_nettype none
module sub_borrow_unit
    import rr_alu_pkg::*;
(
    // operands
    input wire logic [DATA_W-1:0] minuend,
    input wire logic [DATA_W-1:0] subtrahend,
    input wire flags_t flags_in,
    // result
    output var sub_result_t result
);
    logic [DATA_W:0] full_sum;
    logic [4:0] low_sum;

    always_comb
    begin
        // a - m - ~c done as a + ~m + c, so the top bit is the no-borrow carry
        full_sum = {1'b0, minuend} + {1'b0, ~subtrahend} + {{DATA_W{1'b0}}, flags_in.c};
        low_sum = {1'b0, minuend[3:0]} + {1'b0, ~subtrahend[3:0]} + {4'h0, flags_in.c};
        result.diff = full_sum[DATA_W-1:0];
        result.flags.c = full_sum[DATA_W];
        result.flags.ac = low_sum[4];
        result.flags.z = (full_sum[DATA_W-1:0] == 8'h00);
        result.flags.ov = (minuend[DATA_W-1] != subtrahend[DATA_W-1])
            && (full_sum[DATA_W-1] != minuend[DATA_W-1]);
        // signed "greater or equal" view of the subtraction
        result.flags.signed_compare_flag = ~(full_sum[DATA_W-1] ^ result.flags.ov);
        // zero across this byte and the one before: a nonzero previous byte (flags_in.z low) keeps it low
        result.flags.chained_zero_flag = result.flags.z & flags_in.z;
    end
endmodule
`default_nettype wire

// File: logic/rotate_right_subtract_carry_alu.sv
// apb-mapped rotate-right and subtract-with-borrow alu with its own acc, operand and flags
// assumes an apb master on pclk; a command write executes at its access edge
//
// The placing of the registers and register access over APB are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module rotate_right_subtract_carry_alu
    import rr_alu_pkg::*;
(
    // clock, reset, enable
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr
);
    alu_state_t state_reg;
    alu_state_t state_next;
    sub_result_t sub_res;
    logic access;
    logic wr_fire;
    logic known_addr;
    logic bad_cmd;
    op_t cmd_op;

    sub_borrow_unit u_sub (
        .minuend(state_reg.acc),
        .subtrahend(state_reg.mem),
        .flags_in(state_reg.flags),
        .result(sub_res)
    );

    // transfers stall while the enable is low so nothing is taken on a frozen edge
    assign pready = clk_en;
    assign access = psel & penable & clk_en;
    assign wr_fire = access & pwrite & pstrb[0];
    assign known_addr = (paddr == ACC_OFFSET) || (paddr == MEM_OFFSET)
        || (paddr == STATUS_OFFSET) || (paddr == CMD_OFFSET);
    assign cmd_op = op_t'(pwdata[4:0]);
    assign bad_cmd = pwrite && (paddr == CMD_OFFSET) && !((cmd_op == OP_ROTATE_MEM_RIGHT)
        || (cmd_op == OP_ROTATE_RIGHT_TO_ACC) || (cmd_op == OP_ROTATE_RIGHT_THRU_CARRY)
        || (cmd_op == OP_ROTATE_RIGHT_THRU_CARRY_TO_ACC)
        || (cmd_op == OP_SUBTRACT_WITH_BORROW_TO_ACC));
    assign pslverr = psel & penable & (!known_addr || bad_cmd);

    always_comb
    begin
        prdata = 32'h0000_0000;
        case (paddr)
            ACC_OFFSET: prdata[DATA_W-1:0] = state_reg.acc;
            MEM_OFFSET: prdata[DATA_W-1:0] = state_reg.mem;
            STATUS_OFFSET: prdata[FLAG_W-1:0] = state_reg.flags;
            CMD_OFFSET: prdata[4:0] = state_reg.last_op;
            default: prdata = 32'h0000_0000;
        endcase
    end

    always_comb
    begin
        state_next = state_reg;
        if (wr_fire && !pslverr)
        begin
            case (paddr)
                ACC_OFFSET: state_next.acc = pwdata[DATA_W-1:0];
                MEM_OFFSET: state_next.mem = pwdata[DATA_W-1:0];
                STATUS_OFFSET: state_next.flags = flags_t'(pwdata[FLAG_W-1:0]);
                CMD_OFFSET:
                begin
                    state_next.last_op = cmd_op;
                    case (cmd_op)
                        OP_ROTATE_MEM_RIGHT:
                            state_next.mem = {state_reg.mem[0], state_reg.mem[7:1]};
                        OP_ROTATE_RIGHT_TO_ACC:
                            state_next.acc = {state_reg.mem[0], state_reg.mem[7:1]};
                        OP_ROTATE_RIGHT_THRU_CARRY:
                        begin
                            state_next.mem = {state_reg.flags.c, state_reg.mem[7:1]};
                            state_next.flags.c = state_reg.mem[0];
                        end
                        OP_ROTATE_RIGHT_THRU_CARRY_TO_ACC:
                        begin
                            state_next.acc = {state_reg.flags.c, state_reg.mem[7:1]};
                            state_next.flags.c = state_reg.mem[0];
                        end
                        OP_SUBTRACT_WITH_BORROW_TO_ACC:
                        begin
                            state_next.acc = sub_res.diff;
                            state_next.flags = sub_res.flags;
                        end
                        default: state_next.last_op = state_reg.last_op;
                    endcase
                end
                default: state_next = state_reg;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_reg <= '{acc: ACC_RESET, mem: MEM_RESET, flags: FLAGS_RESET,
                last_op: OP_NONE};
        end
        else if (clk_en)
        begin
            state_reg <= state_next;
        end
    end

    // checks
    // one strobe per command so that each check names its own trigger
    logic cmd_fire;
    logic rot_mem_fire;
    logic rot_acc_fire;
    logic rot_carry_fire;
    logic rot_carry_acc_fire;
    logic sub_fire;
    // sign-extended difference: its top bit is the true sign, free of overflow
    logic [DATA_W+1:0] sub_wide;

    assign cmd_fire = wr_fire && (paddr == CMD_OFFSET);
    assign rot_mem_fire = cmd_fire && (cmd_op == OP_ROTATE_MEM_RIGHT);
    assign rot_acc_fire = cmd_fire && (cmd_op == OP_ROTATE_RIGHT_TO_ACC);
    assign rot_carry_fire = cmd_fire && (cmd_op == OP_ROTATE_RIGHT_THRU_CARRY);
    assign rot_carry_acc_fire = cmd_fire && (cmd_op == OP_ROTATE_RIGHT_THRU_CARRY_TO_ACC);
    assign sub_fire = cmd_fire && (cmd_op == OP_SUBTRACT_WITH_BORROW_TO_ACC);
    assign sub_wide = {{2{state_reg.acc[DATA_W-1]}}, state_reg.acc}
        - {{2{state_reg.mem[DATA_W-1]}}, state_reg.mem}
        - {{(DATA_W+1){1'b0}}, ~state_reg.flags.c};

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // rotates: only the named destination and, through carry, c may move
    rot_mem_a: assert property (rot_mem_fire |=>
        state_reg.mem == {$past(state_reg.mem[0]), $past(state_reg.mem[7:1])}
        && $stable(state_reg.flags) && $stable(state_reg.acc))
        else $error("in-place rotate wrong");
    rot_acc_a: assert property (rot_acc_fire |=>
        state_reg.acc == {$past(state_reg.mem[0]), $past(state_reg.mem[7:1])}
        && $stable(state_reg.mem) && $stable(state_reg.flags))
        else $error("rotate to acc wrong");
    rot_carry_a: assert property (rot_carry_fire |=>
        {state_reg.mem, state_reg.flags.c} == {$past(state_reg.flags.c), $past(state_reg.mem)}
        && state_reg.flags.z == $past(state_reg.flags.z)
        && state_reg.flags.ov == $past(state_reg.flags.ov)
        && $stable(state_reg.flags.ac) && $stable(state_reg.acc)
        && $stable(state_reg.flags.signed_compare_flag)
        && $stable(state_reg.flags.chained_zero_flag))
        else $error("rotate through carry wrong");
    rot_carry_acc_a: assert property (rot_carry_acc_fire |=>
        state_reg.acc == {$past(state_reg.flags.c), $past(state_reg.mem[7:1])}
        && state_reg.flags.c == $past(state_reg.mem[0]) && $stable(state_reg.mem)
        && $stable(state_reg.flags.ac) && $stable(state_reg.flags.z)
        && $stable(state_reg.flags.ov)
        && $stable(state_reg.flags.signed_compare_flag)
        && $stable(state_reg.flags.chained_zero_flag))
        else $error("rotate through carry to acc wrong");

    // subtract: result, operand and every flag that it owns
    sub_value_a: assert property (sub_fire |=>
        state_reg.acc == 8'($past(state_reg.acc) - $past(state_reg.mem)
        - {7'h00, ~$past(state_reg.flags.c)}))
        else $error("subtract result wrong");
    sub_keep_a: assert property (sub_fire |=> $stable(state_reg.mem))
        else $error("subtract touched the operand byte");
    sub_carry_a: assert property (sub_fire |=>
        state_reg.flags.c == ({1'b0, $past(state_reg.acc)} >= ({1'b0, $past(state_reg.mem)}
        + {8'h00, ~$past(state_reg.flags.c)})))
        else $error("subtract carry wrong");
    sub_flags_a: assert property (sub_fire |=>
        state_reg.flags.z == (state_reg.acc == 8'h00)
        && state_reg.flags.chained_zero_flag
        == (state_reg.flags.z && $past(state_reg.flags.z)))
        else $error("subtract flags wrong");
    sub_signed_a: assert property (sub_fire |=>
        state_reg.flags.signed_compare_flag == !$past(sub_wide[DATA_W+1])
        && state_reg.flags.ov == ($past(sub_wide[DATA_W+1:DATA_W-1]) != 3'b000
        && $past(sub_wide[DATA_W+1:DATA_W-1]) != 3'b111))
        else $error("subtract signed flags wrong");
    sub_nibble_a: assert property (sub_fire |=>
        state_reg.flags.ac == ({1'b0, $past(state_reg.acc[3:0])}
        >= {1'b0, $past(state_reg.mem[3:0])} + {4'h0, ~$past(state_reg.flags.c)}))
        else $error("subtract nibble carry wrong");

    // plain register writes land at the taking edge and nowhere else
    acc_load_a: assert property (wr_fire && !pslverr && paddr == ACC_OFFSET |=>
        state_reg.acc == $past(pwdata[DATA_W-1:0]))
        else $error("accumulator write lost");
    mem_load_a: assert property (wr_fire && !pslverr && paddr == MEM_OFFSET |=>
        state_reg.mem == $past(pwdata[DATA_W-1:0]))
        else $error("operand write lost");
    status_load_a: assert property (wr_fire && !pslverr && paddr == STATUS_OFFSET |=>
        state_reg.flags == $past(pwdata[FLAG_W-1:0]))
        else $error("status write lost");

    // refused or stalled transfers leave every register as it was
    refused_a: assert property (access && pslverr |=> $stable(state_reg))
        else $error("refused transfer changed state");
    strobe_off_a: assert property (access && pwrite && !pstrb[0] |=> $stable(state_reg))
        else $error("write without low-byte strobe landed");
    bad_code_a: assert property (psel && penable && pwrite && paddr == CMD_OFFSET
        && !$onehot(pwdata[4:0]) |-> pslverr)
        else $error("illegal command code accepted");
    unmapped_read_a: assert property (psel && penable && !pwrite && paddr > CMD_OFFSET
        |-> pslverr && prdata == 32'h0000_0000)
        else $error("unmapped read not refused");
    frozen_a: assert property (!clk_en |=> $stable(state_reg))
        else $error("state moved while disabled");

    // main scenarios, for coverage
    sub_cov: cover property (sub_fire && !state_reg.flags.c);
    rot_chain_cov: cover property (rot_carry_fire ##1 rot_carry_acc_fire);
    err_cov: cover property (pslverr && pready);
    stall_cov: cover property (psel && penable && !pready ##1 psel && penable && pready);
    zero_chain_cov: cover property (sub_fire ##1 state_reg.flags.chained_zero_flag);
endmodule
`default_nettype wire

// File: dv/rotate_right_subtract_carry_alu_tb.sv
// self-checking bench for the rotate-right / subtract-with-borrow alu
// assumes zero wait states while clk_en is high; assertions live in the design files, bus responses are checked here
`timescale 1ns/1ps
`default_nettype none
module rotate_right_subtract_carry_alu_tb
    import rr_alu_pkg::*;
;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic clk_en = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [ADDR_W-1:0] paddr = '0;
    logic [31:0] pwdata = '0;
    logic [3:0] pstrb = 4'hF;
    logic pready;
    logic [31:0] prdata;
    logic pslverr;
    logic [32:0] exp_q[$];
    int err_total = 0;
    int comparisons = 0;
    bit stall = 1'b0;

    always #2.5 pclk = ~pclk;

    rotate_right_subtract_carry_alu dut (.pclk(pclk), .presetn(presetn), .clk_en(clk_en),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(pstrb), .pready(pready), .prdata(prdata), .pslverr(pslverr));

    task automatic check(input logic [32:0] seen, input logic [32:0] want);
        comparisons++;
        if (seen !== want)
        begin
            err_total++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, want);
        end
    endtask

    task automatic give_verdict;
        $display("comparisons=%0d mismatches=%0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // psel stays up between calls so back-to-back setups follow at once
    task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d,
        input logic [32:0] want);
        int n;
        n = 0;
        exp_q.push_back(want);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        clk_en <= !stall;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
            n++;
            if (n == 3)
                clk_en <= 1'b1;
        end
        while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1)
        begin
            err_total++;
            $display("ERROR t=%0t pready stayed low for %0d cycles", $time, n);
            give_verdict();
        end
    endtask

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] v, input logic e);
        logic [31:0] r;
        r = $urandom;
        if (a == CMD_OFFSET || a == STATUS_OFFSET)
            r = 32'h0;
        apb(1'b1, a, {r[31:8], v}, {e, 32'h0});
    endtask

    task automatic rd(input logic [ADDR_W-1:0] a, input logic [7:0] v, input logic e);
        apb(1'b0, a, 32'h0, {e, 24'h0, v});
    endtask

    // every completed access takes the oldest expectation
    always @(posedge pclk)
    begin
        if (presetn && psel && penable && pready === 1'b1)
        begin
            if (exp_q.size() == 0)
            begin
                err_total++;
                $display("ERROR t=%0t unexpected transfer seen=%h", $time, {pslverr, prdata});
            end
            else
                check({pslverr, pwrite ? 32'h0 : prdata}, exp_q.pop_front());
        end
    end

    initial
    begin
        logic [7:0] a, m, s, acc_x, mem_x, st_x;
        logic [8:0] d9;
        logic [4:0] nib;
        op_t op;
        void'($urandom(32'hB8AC));
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rd(ACC_OFFSET, ACC_RESET, 1'b0);
        rd(MEM_OFFSET, MEM_RESET, 1'b0);
        rd(STATUS_OFFSET, {2'b00, FLAGS_RESET}, 1'b0);
        rd(CMD_OFFSET, 8'h00, 1'b0);
        $display("test reset values done");
        for (int k = 0; k < 40; k++)
        begin
            op = op_t'(5'h01 << (k % 5));
            a = $urandom;
            m = $urandom;
            s = $urandom & 8'h3F;
            stall = (k == 7);
            wr(ACC_OFFSET, a, 1'b0);
            wr(MEM_OFFSET, m, 1'b0);
            wr(STATUS_OFFSET, s, 1'b0);
            wr(CMD_OFFSET, {3'b000, op}, 1'b0);
            acc_x = a;
            mem_x = m;
            st_x = s;
            d9 = {1'b0, a} - {1'b0, m} - {8'h00, ~s[0]};
            nib = {1'b0, a[3:0]} + {1'b0, ~m[3:0]} + {4'h0, s[0]};
            case (op)
                OP_ROTATE_MEM_RIGHT: mem_x = {m[0], m[7:1]};
                OP_ROTATE_RIGHT_TO_ACC: acc_x = {m[0], m[7:1]};
                OP_ROTATE_RIGHT_THRU_CARRY: {mem_x, st_x[0]} = {s[0], m};
                OP_ROTATE_RIGHT_THRU_CARRY_TO_ACC: {acc_x, st_x[0]} = {s[0], m};
                default:
                begin
                    acc_x = d9[7:0];
                    st_x[0] = ~d9[8];
                    st_x[1] = nib[4];
                    st_x[2] = (d9[7:0] == 8'h00);
                    st_x[3] = (a[7] != m[7]) && (d9[7] != a[7]);
                    st_x[4] = ~(d9[7] ^ st_x[3]);
                    st_x[5] = st_x[2] & s[2];
                end
            endcase
            rd(ACC_OFFSET, acc_x, 1'b0);
            rd(MEM_OFFSET, mem_x, 1'b0);
            rd(STATUS_OFFSET, st_x, 1'b0);
            rd(CMD_OFFSET, {3'b000, op}, 1'b0);
        end
        $display("test operations done");
        // low strobe, bad command code and unmapped address change nothing
        pstrb <= 4'h0;
        wr(ACC_OFFSET, 8'h5A, 1'b0);
        pstrb <= 4'hF;
        rd(ACC_OFFSET, acc_x, 1'b0);
        wr(CMD_OFFSET, 8'h03, 1'b1);
        wr(12'h010, 8'hFF, 1'b1);
        rd(12'h010, 8'h00, 1'b1);
        rd(CMD_OFFSET, {3'b000, OP_SUBTRACT_WITH_BORROW_TO_ACC}, 1'b0);
        $display("test refusals done");
        // reset in mid-run with the bus idle: every register returns to its reset value
        psel <= 1'b0;
        penable <= 1'b0;
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rd(ACC_OFFSET, ACC_RESET, 1'b0);
        rd(MEM_OFFSET, MEM_RESET, 1'b0);
        rd(STATUS_OFFSET, {2'b00, FLAGS_RESET}, 1'b0);
        rd(CMD_OFFSET, 8'h00, 1'b0);
        $display("test mid-run reset done");
        psel <= 1'b0;
        penable <= 1'b0;
        repeat (2) @(posedge pclk);
        if (exp_q.size() != 0)
        begin
            err_total++;
            $display("ERROR t=%0t %0d expected transfers never completed", $time, exp_q.size());
        end
        give_verdict();
    end
endmodule
`default_nettype wire
